// ### mhc_counter.sv
// Overview of operation
// RQ1 - maintenance reset edge clears alarm, reloads countdown
// RQ2 - operating time ignores maintenance reset
// RQ3 - reset-all edge clears alarm, time, reloads
// RQ4 - enable high advances time; low holds
// RQ5 - alarm sets when countdown reaches zero
// RQ6 - resets-only mode: only resets clear alarm
// RQ7 - idle mode: low enable also clears alarm
// RQ8 - interval limited to 9999 h, 59 m
// RQ9 - operating time saturates at 99999 h
// RQ10 - interval, countdown, time kept across power loss; here i_rst clears all three
// RQ11 - interval may come from external hours value
// RQ12 - offset preset loads interval minus remainder
// RQ13 - running: no preset, interval change copies
// RQ14 - minute tick derived from system clock
// RQ15 - reset edges found against previous sample
`timescale 1ns/10ps
module mhc_counter #(
  parameter longint P_MIN_CYC = mhc_pkg::MIN_CYC
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // machine side pins
  input  wire logic        i_enable,
  input  wire logic        i_maint_reset,
  input  wire logic        i_reset_all,
  input  wire logic [15:0] i_ext_interval_h,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // outputs
  output logic             o_alarm,
  output logic             o_irq
);

  typedef mhc_pkg::mhc_time_type tm_t;

  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [1:0]  prev_q;
  logic        en_s;
  logic        mr_s;
  logic        ra_s;
  logic        mr_rise;
  logic        ra_rise;
  logic [2:0]  ctrl_q;
  tm_t         mi_q;
  tm_t         mi_eff;
  tm_t         mi_prev_q;
  tm_t         ttg_q;
  tm_t         ot_q;
  tm_t         ot_set;
  tm_t         ttg_set;
  logic        mi_chg;
  logic        tick;
  logic        step;
  logic        sat;
  logic        run;
  logic        mode_idle;
  logic        cfg_ot_wr;
  logic        alarm_q;
  logic        alarm_clr;
  logic        alarm_set;
  logic [3:0]  st_q;
  logic [3:0]  ien_q;
  logic [3:0]  st_ev;
  logic [3:0]  st_clr;
  logic        irq_q;
  logic [31:0] rdata_q;
  logic [22:0] mi_tot;
  logic [22:0] ot_tot;
  logic [22:0] rem;

  function automatic logic [31:0] to_word(input tm_t t);
    to_word = {2'h0, t.m, 7'h00, t.h};
  endfunction : to_word

  function automatic logic [22:0] to_min(input tm_t t);
    to_min = 23'(t.h) * mhc_pkg::MIN_PER_H + 23'(t.m);
  endfunction : to_min

  function automatic tm_t from_min(input logic [22:0] x);
    from_min.h = 17'(x / mhc_pkg::MIN_PER_H);
    from_min.m = 6'(x % mhc_pkg::MIN_PER_H);
  endfunction : from_min

  function automatic tm_t clamp(input tm_t t, input logic [16:0] hmax);
    clamp.h = (t.h > hmax) ? hmax : t.h;
    clamp.m = (t.m > mhc_pkg::MIN_MAX) ? mhc_pkg::MIN_MAX : t.m;
  endfunction : clamp

  function automatic tm_t word_time(input logic [31:0] w);
    word_time.h = w[mhc_pkg::TIME_H_LSB +: 17];
    word_time.m = w[mhc_pkg::TIME_M_LSB +: 6];
  endfunction : word_time

  // enable and reset pins pass two flip-flops before use
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {i_reset_all, i_maint_reset, i_enable};
      sync2_q <= sync1_q;
    end
  end

  assign en_s = sync2_q[0];
  assign mr_s = sync2_q[1];
  assign ra_s = sync2_q[2];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_q <= 2'h0;
    end else begin
      prev_q <= {ra_s, mr_s};
    end
  end

  assign mr_rise = mr_s && !prev_q[0]; // see RQ15
  assign ra_rise = ra_s && !prev_q[1]; // see RQ15

  assign run       = ctrl_q[mhc_pkg::CTRL_RUN_BIT];
  assign mode_idle = ctrl_q[mhc_pkg::CTRL_MODE_BIT];
  assign cfg_ot_wr = i_wr && (i_addr == mhc_pkg::OFS_OT_SET) && !run; // see RQ13

  // minute tick restarts whenever run is off
  mhc_tick_gen #(
    .P_CYC  (P_MIN_CYC)
  ) u_tick ( // see RQ14
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_run     (run),
    .o_tick    (tick)
  );

  assign step = tick && en_s && run; // see RQ4
  assign sat  = (ot_q.h == mhc_pkg::OT_H_MAX);

  // control and interval registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_q <= mhc_pkg::CTRL_RST;
      mi_q   <= mhc_pkg::TIME_RST;
      ien_q  <= mhc_pkg::IEN_RST;
    end else if (i_wr) begin
      case (i_addr)
        mhc_pkg::OFS_CTRL:     ctrl_q <= i_wdata[2:0];
        mhc_pkg::OFS_INTERVAL:
          mi_q <= clamp(word_time(i_wdata), mhc_pkg::MI_H_MAX); // see RQ8
        mhc_pkg::OFS_IRQ_EN:   ien_q  <= i_wdata[3:0];
        default:               ;
      endcase
    end
  end

  // interval from register or from another block in whole hours
  always_comb begin
    mi_eff = mi_q;
    if (ctrl_q[mhc_pkg::CTRL_SRC_BIT]) begin // see RQ11
      mi_eff.h = (i_ext_interval_h > 16'(mhc_pkg::MI_H_MAX)) ?
                 mhc_pkg::MI_H_MAX : 17'(i_ext_interval_h);
      mi_eff.m = 6'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mi_prev_q <= mhc_pkg::TIME_RST;
    end else begin
      mi_prev_q <= mi_eff;
    end
  end

  assign mi_chg = (mi_eff != mi_prev_q);

  // offset preset: countdown is interval minus remainder
  assign ot_set = clamp(word_time(i_wdata), mhc_pkg::OT_H_MAX);
  assign mi_tot = to_min(mi_eff);
  assign ot_tot = to_min(ot_set);
  assign rem    = (mi_tot == 23'h0) ? 23'h0 : (ot_tot % mi_tot);
  assign ttg_set = from_min(mi_tot - rem); // see RQ12

  // operating time, kept unless reset-all or a configuration preset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ot_q <= mhc_pkg::TIME_RST;
    end else if (ra_rise) begin
      ot_q <= mhc_pkg::TIME_RST; // see RQ3
    end else if (cfg_ot_wr) begin
      ot_q <= ot_set; // see RQ12
    end else if (step && !sat) begin // see RQ2, RQ4, RQ9
      if (ot_q.m == mhc_pkg::MIN_MAX) begin
        ot_q.h <= ot_q.h + 17'h1;
        ot_q.m <= 6'h00;
      end else begin
        ot_q.m <= ot_q.m + 6'h1;
      end
    end
  end

  // countdown to service
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ttg_q <= mhc_pkg::TIME_RST;
    end else if (ra_rise || mr_rise) begin
      ttg_q <= mi_eff; // see RQ1, RQ3
    end else if (cfg_ot_wr) begin
      ttg_q <= ttg_set; // see RQ12
    end else if (mi_chg) begin
      ttg_q <= mi_eff; // see RQ13
    end else if (step && (ttg_q != '0)) begin // see RQ4
      if (ttg_q.m == 6'h00) begin
        ttg_q.h <= ttg_q.h - 17'h1;
        ttg_q.m <= mhc_pkg::MIN_MAX;
      end else begin
        ttg_q.m <= ttg_q.m - 6'h1;
      end
    end
  end

  // alarm: resets dominate, idle mode adds low enable
  assign alarm_clr = mr_s || ra_s || (mode_idle && !en_s); // see RQ6, RQ7
  assign alarm_set = run && (ttg_q == '0); // see RQ5

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      alarm_q <= 1'b0;
    end else if (alarm_clr) begin
      alarm_q <= 1'b0; // see RQ1, RQ3
    end else if (alarm_set) begin
      alarm_q <= 1'b1; // see RQ5
    end
  end

  // sticky status, set wins over clear
  assign st_ev[mhc_pkg::ST_ALARM] = alarm_set && !alarm_clr && !alarm_q;
  assign st_ev[mhc_pkg::ST_SAT]   = step && sat;
  assign st_ev[mhc_pkg::ST_MAINT] = mr_rise;
  assign st_ev[mhc_pkg::ST_ALL]   = ra_rise;
  assign st_clr = (i_wr && i_addr == mhc_pkg::OFS_IRQ_CLR) ?
                  i_wdata[3:0] : 4'h0;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q  <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      st_q  <= (st_q & ~st_clr) | st_ev;
      irq_q <= |(st_q & ien_q);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        mhc_pkg::OFS_CTRL:
          rdata_q <= {23'h0, alarm_q, 5'h00, ctrl_q};
        mhc_pkg::OFS_INTERVAL: rdata_q <= to_word(mi_eff);
        mhc_pkg::OFS_TTG:      rdata_q <= to_word(ttg_q); // see RQ10
        mhc_pkg::OFS_OT:       rdata_q <= to_word(ot_q);
        mhc_pkg::OFS_STATUS:   rdata_q <= {28'h0, st_q};
        mhc_pkg::OFS_IRQ_EN:   rdata_q <= {28'h0, ien_q};
        default:               rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_alarm = alarm_q;
  assign o_irq   = irq_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  chk_maint_reload: assert property ( // see RQ1
    mr_rise |=> ttg_q == $past(mi_eff))
    else $error("countdown not reloaded on maintenance reset");

  chk_reset_alarm_low: assert property ( // see RQ1
    (mr_s || ra_s) |=> !alarm_q)
    else $error("alarm high while a reset is high");

  chk_ot_keeps_count: assert property ( // see RQ2
    mr_s && !ra_rise && step && !sat && !cfg_ot_wr
    |=> ot_q != $past(ot_q))
    else $error("operating time stalled by maintenance reset");

  chk_maint_keeps_ot: assert property ( // see RQ2
    mr_rise && !ra_rise && !cfg_ot_wr && !step |=> $stable(ot_q))
    else $error("operating time moved on maintenance reset");

  chk_reset_all: assert property ( // see RQ3
    ra_rise |=> (ot_q == '0) && (ttg_q == $past(mi_eff)))
    else $error("reset-all did not clear and reload");

  chk_idle_hold: assert property ( // see RQ4
    !en_s && !ra_rise && !mr_rise && !cfg_ot_wr && !mi_chg
    |=> $stable(ot_q) && $stable(ttg_q))
    else $error("counts moved with enable low");

  chk_alarm_on_zero: assert property ( // see RQ5
    run && ttg_q == '0 && !alarm_clr |=> alarm_q)
    else $error("alarm missing at zero countdown");

  chk_resets_mode: assert property ( // see RQ6
    !mode_idle && alarm_q && !mr_s && !ra_s |=> alarm_q)
    else $error("alarm dropped without a reset");

  chk_idle_clear: assert property ( // see RQ7
    mode_idle && !en_s |=> !alarm_q)
    else $error("alarm kept with enable low in idle mode");

  chk_interval_range: assert property ( // see RQ8
    mi_q.h <= mhc_pkg::MI_H_MAX && mi_q.m <= mhc_pkg::MIN_MAX)
    else $error("interval out of range");

  chk_ot_saturate: assert property ( // see RQ9
    sat && !ra_rise && !cfg_ot_wr |=> ot_q == $past(ot_q))
    else $error("operating time passed its limit");

  chk_preset_rem: assert property ( // see RQ12
    cfg_ot_wr && !ra_rise && !mr_rise |=> ttg_q == $past(ttg_set))
    else $error("countdown not set from remainder");

  chk_run_no_preset: assert property ( // see RQ13
    run && !ra_rise && !step |=> ot_q == $past(ot_q))
    else $error("operating time preset while running");

  cov_alarm_rise: cover property (!alarm_q ##1 alarm_q);
  cov_maint_reset: cover property (alarm_q ##1 mr_rise);
  cov_idle_clear: cover property (mode_idle && alarm_q ##1 !en_s);
  cov_ot_sat: cover property (step && sat);
  cov_maint_run: cover property (mr_s && step);

endmodule : mhc_counter

// ### mhc_counter_tb_top.sv
`timescale 1ns/10ps
module mhc_counter_tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        run = 1'b0, mreq = 1'b0, areq = 1'b0;
  logic        en, mrst, arst;
  logic [15:0] i_ext_interval_h = 16'h0;
  logic [7:0]  i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
  logic [31:0] o_rdata, seed = 32'h5CEF;
  logic        o_alarm, o_irq;
  logic [16:0] eh;
  logic [31:0] exp_q[$];
  int          err_total = 0, tests_run = 0;

  initial forever #5 i_ref_clk = ~i_ref_clk;

  mhc_machine_model mhc_machine_model_i (.i_ref_clk(i_ref_clk), .i_run(run),
    .i_maint_req(mreq), .i_all_req(areq), .o_enable(en),
    .o_maint_reset(mrst), .o_reset_all(arst));

  mhc_counter #(.P_MIN_CYC(64'h8)) mhc_counter_i (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_enable(en), .i_maint_reset(mrst),
    .i_reset_all(arst), .i_ext_interval_h(i_ext_interval_h),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_alarm(o_alarm), .o_irq(o_irq));

  function automatic logic [31:0] tw(logic [16:0] h, logic [5:0] m);
    return {2'h0, m, 7'h0, h};
  endfunction : tw

  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic cmp_pin(string what, logic e, logic g);
    cmp(what, {31'h0, e}, {31'h0, g});
  endtask : cmp_pin

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic press(logic all);
    @(posedge i_ref_clk);
    if (all) areq <= 1'b1; else mreq <= 1'b1;
    @(posedge i_ref_clk);
    areq <= 1'b0;
    mreq <= 1'b0;
  endtask : press

  task automatic cyc(int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : cyc

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // read data stand only in the cycle after the strobe
  always @(posedge i_ref_clk) begin
    if (rd_seen) cmp("rdata", exp_q.pop_front(), o_rdata);
    rd_seen <= i_rd;
  end

  initial begin
    cyc(20000);
    err_total++;
    report_and_stop;
  end

  initial begin
    cyc(5);
    i_rst <= 1'b0;
    rd(mhc_pkg::OFS_CTRL, 32'h0);
    rd(mhc_pkg::OFS_OT, 32'h0);
    rd(mhc_pkg::OFS_STATUS, 32'h0);
    rd(8'h20, 32'h0);
    wr(mhc_pkg::OFS_INTERVAL, tw(17'h1FFFF, 6'h3F));
    rd(mhc_pkg::OFS_INTERVAL, tw(mhc_pkg::MI_H_MAX, mhc_pkg::MIN_MAX));
    rd(mhc_pkg::OFS_TTG, tw(mhc_pkg::MI_H_MAX, mhc_pkg::MIN_MAX));
    wr(mhc_pkg::OFS_INTERVAL, tw(17'h1E, 6'h0));
    wr(mhc_pkg::OFS_OT_SET, tw(17'h64, 6'h0));
    rd(mhc_pkg::OFS_TTG, tw(17'h14, 6'h0));
    wr(mhc_pkg::OFS_INTERVAL, tw(17'h0, 6'h2));
    wr(mhc_pkg::OFS_CTRL, 32'h4);
    wr(mhc_pkg::OFS_OT_SET, tw(17'h5, 6'h0));
    rd(mhc_pkg::OFS_OT, tw(17'h64, 6'h0));
    run <= 1'b1;
    for (int k = 0; k < 300 && o_alarm !== 1'b1; k++) cyc(1);
    cmp_pin("alarm set", 1'b1, o_alarm);
    run <= 1'b0;
    cyc(4);
    rd(mhc_pkg::OFS_TTG, 32'h0);
    rd(mhc_pkg::OFS_OT, tw(17'h64, 6'h2));
    cyc(30);
    rd(mhc_pkg::OFS_OT, tw(17'h64, 6'h2));
    cmp_pin("alarm idle", 1'b1, o_alarm);
    rd(mhc_pkg::OFS_CTRL, 32'h104);
    wr(mhc_pkg::OFS_CTRL, 32'h5);
    cyc(2);
    cmp_pin("alarm idle clr", 1'b0, o_alarm);
    wr(mhc_pkg::OFS_CTRL, 32'h4);
    cyc(3);
    cmp_pin("alarm again", 1'b1, o_alarm);
    press(1'b0);
    cyc(4);
    cmp_pin("alarm maint", 1'b0, o_alarm);
    cyc(6);
    rd(mhc_pkg::OFS_TTG, tw(17'h0, 6'h2));
    rd(mhc_pkg::OFS_OT, tw(17'h64, 6'h2));
    rd(mhc_pkg::OFS_STATUS, 32'h5);
    cmp_pin("irq masked", 1'b0, o_irq);
    wr(mhc_pkg::OFS_IRQ_EN, 32'h4);
    cyc(2);
    cmp_pin("irq on", 1'b1, o_irq);
    wr(mhc_pkg::OFS_IRQ_CLR, 32'hF);
    cyc(2);
    cmp_pin("irq clr", 1'b0, o_irq);
    press(1'b1);
    cyc(10);
    rd(mhc_pkg::OFS_OT, 32'h0);
    rd(mhc_pkg::OFS_TTG, tw(17'h0, 6'h2));
    cmp_pin("alarm all", 1'b0, o_alarm);
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      i_ext_interval_h <= seed[15:0];
      eh = ({1'b0, seed[15:0]} > mhc_pkg::MI_H_MAX) ? mhc_pkg::MI_H_MAX
                                                    : {1'b0, seed[15:0]};
      wr(mhc_pkg::OFS_CTRL, 32'h6);
      cyc(4);
      rd(mhc_pkg::OFS_TTG, tw(eh, 6'h0));
    end
    wr(mhc_pkg::OFS_CTRL, 32'h0);
    wr(mhc_pkg::OFS_OT_SET, tw(mhc_pkg::OT_H_MAX - 17'h1, 6'h3A));
    wr(mhc_pkg::OFS_CTRL, 32'h4);
    run <= 1'b1;
    // held maintenance reset spans one tick while enabled
    repeat (3) press(1'b0);
    cyc(54);
    rd(mhc_pkg::OFS_OT, tw(mhc_pkg::OT_H_MAX, 6'h0));
    rd(mhc_pkg::OFS_STATUS, 32'hF);
    cmp_pin("alarm end", 1'b1, o_alarm);
    cmp_pin("irq maint", 1'b1, o_irq);
    run <= 1'b0;
    cyc(3);
    report_and_stop;
  end
endmodule : mhc_counter_tb_top

// ### mhc_machine_model.sv
`timescale 1ns/10ps
module mhc_machine_model (
  // clock
  input  wire logic i_ref_clk,
  // requests from the bench
  input  wire logic i_run,
  input  wire logic i_maint_req,
  input  wire logic i_all_req,
  // pins toward the block
  output logic      o_enable,
  output logic      o_maint_reset,
  output logic      o_reset_all
);
  logic       en_q  = 1'b0;
  logic [2:0] m_q   = 3'h0;
  logic [2:0] a_q   = 3'h0;

  always_ff @(posedge i_ref_clk) begin
    en_q <= i_run;
  end

  // a pressed reset stays high for four cycles, like a held push button
  always_ff @(posedge i_ref_clk) begin
    m_q <= i_maint_req ? 3'h4 : ((m_q != 3'h0) ? m_q - 3'h1 : 3'h0);
    a_q <= i_all_req ? 3'h4 : ((a_q != 3'h0) ? a_q - 3'h1 : 3'h0);
  end

  assign o_enable      = en_q;
  assign o_maint_reset = (m_q != 3'h0);
  assign o_reset_all   = (a_q != 3'h0);
endmodule : mhc_machine_model

// ### mhc_pkg.sv
package mhc_pkg;

  // time fields
  localparam int HOUR_W = 17;
  localparam int MIN_W  = 6;

  typedef struct packed {
    logic [16:0] h;
    logic [5:0]  m;
  } mhc_time_type;

  localparam logic [16:0] MI_H_MAX  = 17'h0270F;
  localparam logic [16:0] OT_H_MAX  = 17'h1869F;
  localparam logic [5:0]  MIN_MAX   = 6'h3B;
  localparam logic [22:0] MIN_PER_H = 23'h00003C;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_INTERVAL = 8'h04;
  localparam logic [7:0] OFS_OT_SET  = 8'h08;
  localparam logic [7:0] OFS_TTG     = 8'h0C;
  localparam logic [7:0] OFS_OT      = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h1C;

  // control fields
  localparam int CTRL_W         = 3;
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_SRC_BIT   = 1;
  localparam int CTRL_RUN_BIT   = 2;
  localparam int CTRL_ALARM_BIT = 8;

  // time word fields
  localparam int TIME_H_LSB = 0;
  localparam int TIME_M_LSB = 24;

  // status fields
  localparam int ST_W        = 4;
  localparam int ST_ALARM    = 0;
  localparam int ST_SAT      = 1;
  localparam int ST_MAINT    = 2;
  localparam int ST_ALL      = 3;

  // reset values
  localparam logic [2:0]   CTRL_RST = 3'h0;
  localparam logic [3:0]   IEN_RST  = 4'h0;
  localparam mhc_time_type TIME_RST = '0;

  // minute tick
  localparam longint MINUTE_S = 64'h3C;
  localparam longint CLK_HZ   = 64'h5F5E100;
  localparam longint MIN_CYC  = MINUTE_S * CLK_HZ;

endpackage : mhc_pkg

// ### mhc_tick_gen.sv
`timescale 1ns/10ps
module mhc_tick_gen #(
  parameter longint P_CYC = mhc_pkg::MIN_CYC
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_run,
  // tick
  output logic      o_tick
);

  logic [32:0] cnt_q;
  logic        tick_q;

  // one pulse per minute of running time
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_run) begin
      cnt_q  <= 33'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == 33'(P_CYC - 1)) begin // see RQ14
      cnt_q  <= 33'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 33'h1;
      tick_q <= 1'b0;
    end
  end

  assign o_tick = tick_q;

  chk_tick_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tick_q |=> !tick_q) // see RQ14
    else $error("minute tick longer than one cycle");

endmodule : mhc_tick_gen
